// File: logic/vipu_core.sv
// Vectored interrupt priority unit: APB registers, arbitration, nesting stack
//
// Function
// - One non-maskable node and fourteen maskable nodes are offered to the core.
// - Each source has a fixed vector that the core fetches to serve it.
// - Each node is gated by its own enable bit; the three node-five sources share bit 5; disabled ones never vector.
// - Maskable vectors run 0003 to 006B in steps of eight; enables split 6/8.
// - Node five at 002B is shared by timer 2, divider overflow and LIN.
// - Nodes ten to thirteen serve the four capture/compare node pointers.
// - Each maskable node takes one of four levels from two priority register pairs.
// - Non-maskable node outranks every maskable level and preempts any maskable service.
// - Running service is preempted only by a strictly higher level.
// - Service at the topmost level is never preempted by maskable sources.
// - Simultaneous requests of different levels: highest level wins.
// - Equal levels resolved by fixed polling, external interrupt 0 first.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "vipu_params.svh"
module vipu_core (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [13:0] node_req,
    input  wire logic [2:0]  node5_req,
    input  wire logic [5:0]  nmi_src,
    input  wire logic        vec_ack,
    input  wire logic        reti,
    output logic             int_req,
    output logic      [15:0] int_vector,
    output logic             irq
);
    logic [7:0] ena_q, enb_q, pla_q, pha_q, plb_q, phb_q, nmi_control_reg_q;
    logic [7:0] ena_d, enb_d, pla_d, pha_d, plb_d, phb_d, nmi_control_reg_d;
    logic [31:0] prdata_d;
    logic        pready_d, pslverr_d;
    logic [2:0]  irq_en_q, irq_en_d, irq_clr, irq_stat;
    logic        irq_o;
    logic        wr_acc, rd_acc, mapped;

    // A write lands at the edge where the master sees pready high, never earlier
    assign wr_acc = psel && penable && pwrite && pready;
    assign rd_acc = psel && penable && !pwrite && !pready;

    always_comb begin
        unique case (paddr)
            `VIPU_OFS_ENA, `VIPU_OFS_ENB, `VIPU_OFS_PLA, `VIPU_OFS_PHA,
            `VIPU_OFS_PLB, `VIPU_OFS_PHB, `VIPU_OFS_NMI_CONTROL_REG, `VIPU_OFS_VECSTAT,
            `VIPU_OFS_IRQ_STAT, `VIPU_OFS_IRQ_EN, `VIPU_OFS_IRQ_CLR: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Register writes; the slave answers one cycle after the access phase begins
    always_comb begin
        ena_d    = ena_q;
        enb_d    = enb_q;
        pla_d    = pla_q;
        pha_d    = pha_q;
        plb_d    = plb_q;
        phb_d    = phb_q;
        nmi_control_reg_d = nmi_control_reg_q;
        irq_en_d = irq_en_q;
        irq_clr  = 3'h0;
        if (wr_acc) begin
            unique case (paddr)
                `VIPU_OFS_ENA:      ena_d    = {2'h0, pwdata[5:0]};
                `VIPU_OFS_ENB:      enb_d    = pwdata[7:0];
                `VIPU_OFS_PLA:      pla_d    = {2'h0, pwdata[5:0]};
                `VIPU_OFS_PHA:      pha_d    = {2'h0, pwdata[5:0]};
                `VIPU_OFS_PLB:      plb_d    = pwdata[7:0];
                `VIPU_OFS_PHB:      phb_d    = pwdata[7:0];
                `VIPU_OFS_NMI_CONTROL_REG:   nmi_control_reg_d = {2'h0, pwdata[5:0]};
                `VIPU_OFS_IRQ_EN:   irq_en_d = pwdata[2:0];
                `VIPU_OFS_IRQ_CLR:  irq_clr  = pwdata[2:0];
                default: ;
            endcase
        end
    end

    // Per-node enable and two-bit level: high bit from the H register
    logic [13:0] node_en, node_raw, node_act;
    logic [27:0] node_lvl;
    logic [13:0] lvl_hi, lvl_lo;
    assign node_en = {enb_q, ena_q[5:0]};
    assign lvl_hi  = {phb_q, pha_q[5:0]};
    assign lvl_lo  = {plb_q, pla_q[5:0]};

    genvar g;
    generate
        for (g = 0; g < `VIPU_NODES; g++) begin : g_node
            assign node_lvl[2*g +: 2] = {lvl_hi[g], lvl_lo[g]};
            if (g == 5) begin : g_shared
                assign node_raw[g] = node_req[g] | (|node5_req);
            end else begin : g_single
                assign node_raw[g] = node_req[g];
            end
            assign node_act[g] = node_raw[g] & node_en[g];
        end
    endgenerate

    logic       win_hit;
    logic [3:0] win_node;
    logic [1:0] win_lvl;
    vipu_arbiter u_arb (
        .req      (node_act),
        .lvl      (node_lvl),
        .hit      (win_hit),
        .node     (win_node),
        .node_lvl (win_lvl)
    );

    logic nmi_hit;
    assign nmi_hit = |(nmi_src & nmi_control_reg_q[5:0]);

    // Nesting: one bit per active level; topmost set bit is the running level
    vipu_pkg::vipu_lvl_mask_t act_q, act_d;
    vipu_pkg::vipu_state_t    st_q, st_d;
    logic        int_req_d;
    logic [15:0] vec_q, vec_d;
    logic        pend_nmi_q, pend_nmi_d;
    logic [1:0]  pend_lvl_q, pend_lvl_d;
    logic        may_preempt, nmi_busy;
    logic [2:0]  evt;

    assign nmi_busy = act_q[4];

    always_comb begin
        may_preempt = 1'b1;
        // Strictly higher only: any active level at or above the winner blocks it
        for (int l = 0; l < 4; l++) begin
            if (act_q[l] && 2'(l) >= win_lvl) begin
                may_preempt = 1'b0;
            end
        end
        if (nmi_busy) begin
            may_preempt = 1'b0;
        end
    end

    always_comb begin
        st_d       = st_q;
        act_d      = act_q;
        vec_d      = vec_q;
        pend_nmi_d = pend_nmi_q;
        pend_lvl_d = pend_lvl_q;
        int_req_d  = 1'b0;
        evt        = 3'h0;
        unique case (st_q)
            vipu_pkg::VIPU_IDLE: begin
                if (nmi_hit && !nmi_busy) begin
                    vec_d      = `VIPU_VEC_NMI;
                    pend_nmi_d = 1'b1;
                    st_d       = vipu_pkg::VIPU_GRANT;
                    int_req_d  = 1'b1;
                end else if (win_hit && may_preempt) begin
                    vec_d      = `VIPU_VEC_BASE + 16'(win_node) * `VIPU_VEC_STEP;
                    pend_nmi_d = 1'b0;
                    pend_lvl_d = win_lvl;
                    st_d       = vipu_pkg::VIPU_GRANT;
                    int_req_d  = 1'b1;
                end
            end
            vipu_pkg::VIPU_GRANT: begin
                int_req_d = 1'b1;
                if (vec_ack) begin
                    int_req_d = 1'b0;
                    evt[`VIPU_EVT_VECTOR] = 1'b1;
                    evt[`VIPU_EVT_NMI]    = pend_nmi_q;
                    if (pend_nmi_q) begin
                        act_d[4] = 1'b1;
                    end else begin
                        act_d[pend_lvl_q] = 1'b1;
                    end
                    st_d = vipu_pkg::VIPU_HOLD;
                end
            end
            vipu_pkg::VIPU_HOLD: begin
                // One cycle for the new active level to settle before rearbitration
                st_d = vipu_pkg::VIPU_IDLE;
            end
        endcase
        if (reti && st_q != vipu_pkg::VIPU_GRANT) begin
            evt[`VIPU_EVT_RETURN] = 1'b1;
            // Release only the topmost active level
            if (act_q[4]) begin
                act_d[4] = 1'b0;
            end else if (act_q[3]) begin
                act_d[3] = 1'b0;
            end else if (act_q[2]) begin
                act_d[2] = 1'b0;
            end else if (act_q[1]) begin
                act_d[1] = 1'b0;
            end else begin
                act_d[0] = 1'b0;
            end
        end
    end

    vipu_irq u_irq (
        .pclk    (pclk),
        .presetn (presetn),
        .evt     (evt),
        .clr     (irq_clr),
        .en      (irq_en_q),
        .stat_q  (irq_stat),
        .irq_q   (irq_o)
    );

    always_comb begin
        prdata_d  = 32'h0;
        pready_d  = psel && penable && !pready;
        pslverr_d = psel && penable && !pready && !mapped;
        if (rd_acc) begin
            unique case (paddr)
                `VIPU_OFS_ENA:      prdata_d = {24'h0, ena_q};
                `VIPU_OFS_ENB:      prdata_d = {24'h0, enb_q};
                `VIPU_OFS_PLA:      prdata_d = {24'h0, pla_q};
                `VIPU_OFS_PHA:      prdata_d = {24'h0, pha_q};
                `VIPU_OFS_PLB:      prdata_d = {24'h0, plb_q};
                `VIPU_OFS_PHB:      prdata_d = {24'h0, phb_q};
                `VIPU_OFS_NMI_CONTROL_REG:   prdata_d = {24'h0, nmi_control_reg_q};
                `VIPU_OFS_VECSTAT:  prdata_d = {8'h0, 3'h0, act_q, vec_q};
                `VIPU_OFS_IRQ_STAT: prdata_d = {29'h0, irq_stat};
                `VIPU_OFS_IRQ_EN:   prdata_d = {29'h0, irq_en_q};
                default:            prdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ena_q      <= `VIPU_RST_REG;
            enb_q      <= `VIPU_RST_REG;
            pla_q      <= `VIPU_RST_REG;
            pha_q      <= `VIPU_RST_REG;
            plb_q      <= `VIPU_RST_REG;
            phb_q      <= `VIPU_RST_REG;
            nmi_control_reg_q   <= `VIPU_RST_REG;
            irq_en_q   <= 3'h0;
            act_q      <= 5'h00;
            st_q       <= vipu_pkg::VIPU_IDLE;
            vec_q      <= 16'h0000;
            pend_nmi_q <= 1'b0;
            pend_lvl_q <= 2'h0;
            int_req    <= 1'b0;
            prdata     <= 32'h0;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
        end else begin
            ena_q      <= ena_d;
            enb_q      <= enb_d;
            pla_q      <= pla_d;
            pha_q      <= pha_d;
            plb_q      <= plb_d;
            phb_q      <= phb_d;
            nmi_control_reg_q   <= nmi_control_reg_d;
            irq_en_q   <= irq_en_d;
            act_q      <= act_d;
            st_q       <= st_d;
            vec_q      <= vec_d;
            pend_nmi_q <= pend_nmi_d;
            pend_lvl_q <= pend_lvl_d;
            int_req    <= int_req_d;
            prdata     <= prdata_d;
            pready     <= pready_d;
            pslverr    <= pslverr_d;
        end
    end

    assign int_vector = vec_q;
    assign irq        = irq_o;

    // Checks on arbitration, nesting and the bus answer
    a_vec_range: assert property (@(posedge pclk) disable iff (!presetn)
        int_req |-> (int_vector == `VIPU_VEC_NMI ||
                     (int_vector[2:0] == 3'h3 && int_vector <= 16'h006B)))
        else $error("vector outside table");

    a_nmi_first: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == vipu_pkg::VIPU_IDLE && nmi_hit && !nmi_busy) |=>
        (int_req && int_vector == `VIPU_VEC_NMI))
        else $error("non-maskable request not vectored first");

    a_no_nmi_nest: assert property (@(posedge pclk) disable iff (!presetn)
        (act_q[4] && st_q == vipu_pkg::VIPU_IDLE) |=> !$rose(int_req))
        else $error("service preempted during non-maskable");

    a_disabled_gated: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == vipu_pkg::VIPU_IDLE && !nmi_hit && node_act == 14'h0) |=> !int_req)
        else $error("disabled source vectored");

    a_strict_higher: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == vipu_pkg::VIPU_IDLE && !nmi_hit && win_hit && act_q[win_lvl]) |=> !int_req)
        else $error("equal level preempted");

    a_top_level: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == vipu_pkg::VIPU_IDLE && !nmi_hit && act_q[3]) |=> !int_req)
        else $error("top level preempted");

    a_grant_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (int_req && !vec_ack) |=> (int_req && $stable(int_vector)))
        else $error("request dropped before acknowledge");

    a_level_entry: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == vipu_pkg::VIPU_GRANT && vec_ack && !pend_nmi_q && !reti) |=>
        act_q[$past(pend_lvl_q)])
        else $error("level not recorded on entry");

    a_poll_order: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == vipu_pkg::VIPU_IDLE && !nmi_hit && may_preempt && node_act[0] &&
         node_lvl[1:0] == win_lvl) |=> (int_vector == `VIPU_VEC_BASE))
        else $error("polling order broken");

    a_level_release: assert property (@(posedge pclk) disable iff (!presetn)
        (reti && st_q != vipu_pkg::VIPU_GRANT && act_q[4]) |=> !act_q[4])
        else $error("non-maskable level not released on return");

    a_nmi_masked: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == vipu_pkg::VIPU_IDLE && (|nmi_src) && !nmi_hit && !win_hit) |=> !int_req)
        else $error("disabled non-maskable source vectored");

    a_shared_node: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == vipu_pkg::VIPU_IDLE && !nmi_hit && node_act == 14'h0020 && act_q == 5'h00)
        |=> (int_vector == `VIPU_VEC_BASE + 16'h0005 * `VIPU_VEC_STEP))
        else $error("shared node not vectored");

    // Answer stands one cycle; a strobe held past it is answered again every other cycle
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held longer than one cycle");
endmodule
`default_nettype wire

// File: include/vipu_params.svh
// Offsets, field positions, reset values and vector constants of the interrupt priority unit
`ifndef VIPU_PARAMS_SVH
`define VIPU_PARAMS_SVH
`define VIPU_OFS_ENA        12'h000
`define VIPU_OFS_ENB        12'h004
`define VIPU_OFS_PLA        12'h008
`define VIPU_OFS_PHA        12'h00C
`define VIPU_OFS_PLB        12'h010
`define VIPU_OFS_PHB        12'h014
`define VIPU_OFS_NMI_CONTROL_REG     12'h018
`define VIPU_OFS_VECSTAT    12'h01C
`define VIPU_OFS_IRQ_STAT   12'h020
`define VIPU_OFS_IRQ_EN     12'h024
`define VIPU_OFS_IRQ_CLR    12'h028
`define VIPU_NODES          14
`define VIPU_NMI_SRCS       6
`define VIPU_ENA_BITS       6
`define VIPU_ENB_BITS       8
`define VIPU_VEC_BASE       16'h0003
`define VIPU_VEC_STEP       16'h0008
`define VIPU_VEC_NMI        16'h0073
`define VIPU_RST_REG        8'h00
`define VIPU_EVT_VECTOR     0
`define VIPU_EVT_RETURN     1
`define VIPU_EVT_NMI        2
`endif

// File: include/vipu_pkg.sv
// Types of the interrupt priority unit
package vipu_pkg;
    typedef enum logic [2:0] {
        VIPU_IDLE  = 3'b001,
        VIPU_GRANT = 3'b010,
        VIPU_HOLD  = 3'b100
    } vipu_state_t;
    // Active level stack: bit 4 is non-maskable, bits 3..0 the maskable levels
    typedef logic [4:0] vipu_lvl_mask_t;
endpackage

// File: logic/vipu_arbiter.sv
// Picks the winning maskable node: highest level first, then fixed polling order
`timescale 1ns/10ps
`default_nettype none
module vipu_arbiter (
    input  wire logic [13:0] req,
    input  wire logic [27:0] lvl,
    output logic             hit,
    output logic [3:0]       node,
    output logic [1:0]       node_lvl
);
    always_comb begin
        hit      = 1'b0;
        node     = 4'h0;
        node_lvl = 2'h0;
        // Scan from last poll position down so the lowest index wins ties
        for (int i = 13; i >= 0; i--) begin
            if (req[i] && (!hit || lvl[2*i +: 2] >= node_lvl)) begin
                hit      = 1'b1;
                node     = 4'(i);
                node_lvl = lvl[2*i +: 2];
            end
        end
    end
endmodule
`default_nettype wire

// File: logic/vipu_irq.sv
// Sticky event status with enable and write-one clear, one level interrupt
`timescale 1ns/10ps
`default_nettype none
module vipu_irq (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [2:0] evt,
    input  wire logic [2:0] clr,
    input  wire logic [2:0] en,
    output logic      [2:0] stat_q,
    output logic            irq_q
);
    logic [2:0] stat_d;
    always_comb begin
        // Set wins over a clear in the same cycle
        stat_d = (stat_q & ~clr) | evt;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= 3'h0;
            irq_q  <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq_q  <= |(stat_d & en);
        end
    end
endmodule
`default_nettype wire

// File: verification/vipu_core_model.sv
// Behavioural processor core and request sources facing the priority unit
`timescale 1ns/10ps
`default_nettype none
module vipu_core_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        int_req,
    input  wire logic [15:0] int_vector,
    input  wire logic [13:0] set_req,
    input  wire logic [2:0]  set_n5,
    input  wire logic [5:0]  set_nmi,
    input  wire logic        do_ret,
    input  wire logic [2:0]  ack_dly,
    output logic             vec_ack,
    output logic             reti,
    output logic      [13:0] node_req,
    output logic      [2:0]  node5_req,
    output logic      [5:0]  nmi_src
);
    logic [2:0] wait_q;
    logic [3:0] node;
    assign node = 4'((int_vector - 16'h0003) >> 3);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vec_ack <= 1'b0;
            reti <= 1'b0;
            node_req <= '0;
            node5_req <= '0;
            nmi_src <= '0;
            wait_q <= '0;
        end else begin
            vec_ack <= 1'b0;
            reti <= do_ret;
            node_req <= node_req | set_req;
            node5_req <= node5_req | set_n5;
            nmi_src <= nmi_src | set_nmi;
            // Ack delay is set per pass, so both prompt and slow cores are seen
            if (int_req && !vec_ack) begin
                wait_q <= wait_q + 3'h1;
                if (wait_q >= ack_dly) begin
                    vec_ack <= 1'b1;
                    wait_q <= '0;
                end
            end
            // Entering the vector clears the flag that raised it
            if (int_req && vec_ack) begin
                if (int_vector == 16'h0073) begin
                    nmi_src <= '0;
                end else begin
                    node_req[node] <= 1'b0;
                    if (node == 4'h5) begin
                        node5_req <= '0;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: verification/vipu_core_tb.sv
// Self-checking bench: registers, vectoring, priority, nesting, events
`timescale 1ns/10ps
`default_nettype none
`include "vipu_params.svh"
module vipu_core_tb;
    logic        pclk, presetn, psel, penable, pwrite, do_ret, pready, pslverr;
    logic        vec_ack, reti, int_req, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [13:0] node_req, set_req, rm;
    logic [2:0]  node5_req, set_n5, ack_dly;
    logic [5:0]  nmi_src, set_nmi;
    logic [15:0] int_vector;
    logic [32:0] rd_q[$];
    logic [32:0] rexp;
    logic [15:0] vec_q[$];
    logic [1:0]  lv[14];
    int          err_count, check_count, ack_n;

    vipu_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .node_req(node_req), .node5_req(node5_req), .nmi_src(nmi_src),
        .vec_ack(vec_ack), .reti(reti), .int_req(int_req), .int_vector(int_vector), .irq(irq));
    vipu_core_model i_core (.pclk(pclk), .presetn(presetn), .int_req(int_req),
        .int_vector(int_vector), .set_req(set_req), .set_n5(set_n5), .set_nmi(set_nmi),
        .do_ret(do_ret), .ack_dly(ack_dly), .vec_ack(vec_ack), .reti(reti),
        .node_req(node_req), .node5_req(node5_req), .nmi_src(nmi_src));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Expected {slverr, data} is queued; the monitor compares at the pready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        rd_q.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask

    task automatic set_lvls();
        logic [13:0] lo, hi;
        for (int i = 0; i < 14; i++) begin
            lo[i] = lv[i][0];
            hi[i] = lv[i][1];
        end
        wr(`VIPU_OFS_PLA, 32'(lo[5:0]));
        wr(`VIPU_OFS_PHA, 32'(hi[5:0]));
        wr(`VIPU_OFS_PLB, 32'(lo[13:6]));
        wr(`VIPU_OFS_PHB, 32'(hi[13:6]));
    endtask

    task automatic raise(input logic [13:0] r, input logic [2:0] f, input logic [5:0] m);
        @(posedge pclk);
        set_req <= r;
        set_n5 <= f;
        set_nmi <= m;
        @(posedge pclk);
        set_req <= '0;
        set_n5 <= '0;
        set_nmi <= '0;
    endtask

    task automatic next_ack();
        int s, k;
        s = ack_n;
        k = 0;
        while (ack_n == s && k < 400) begin
            @(posedge pclk);
            k++;
        end
        chk("ack_count", 32'(s + 1), 32'(ack_n));
    endtask

    // Waits out the hold cycle so the return is never dropped
    task automatic ret();
        repeat (3) @(posedge pclk);
        do_ret <= 1'b1;
        @(posedge pclk);
        do_ret <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            rexp = rd_q.pop_front();
            chk("pslverr", 32'(rexp[32]), 32'(pslverr));
            if (!pwrite) chk("prdata", rexp[31:0], prdata);
        end
        if (int_req === 1'b1 && vec_ack === 1'b1) begin
            ack_n <= ack_n + 1;
            chk("int_vector", 32'(vec_q.pop_front()), 32'(int_vector));
        end
    end

    // Every phase needs well under a few thousand cycles
    initial begin
        idle(40000);
        err_count++;
        final_report();
    end

    initial begin
        {psel, penable, pwrite, do_ret} = 4'h0;
        paddr = '0;
        pwdata = '0;
        {set_req, set_n5, set_nmi, ack_dly} = '0;
        {err_count, check_count, ack_n} = '0;
        presetn = 1'b0;
        void'($urandom(30338));
        idle(12);
        presetn <= 1'b1;
        for (int a = 0; a < 10; a++) rd(12'(4 * a), 32'h0);
        apb(1'($urandom_range(1, 0)), 12'h02C, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 12'h030, 32'hFF, {1'b1, 32'h0});
        wr(`VIPU_OFS_ENA, 32'h3F);
        wr(`VIPU_OFS_ENB, 32'hFF);
        wr(`VIPU_OFS_IRQ_EN, 32'h7);
        rd(`VIPU_OFS_ENA, 32'h3F);
        // Pass 0 is pure polling order, pass 1 random levels
        for (int p = 0; p < 2; p++) begin
            ack_dly <= 3'($urandom_range(7, 0));
            for (int i = 0; i < 14; i++) lv[i] = (p == 0) ? 2'h0 : 2'($urandom_range(3, 0));
            rm = (p == 0) ? 14'h3FFF : 14'($urandom_range(16383, 1));
            set_lvls();
            for (int l = 3; l >= 0; l--) begin
                for (int i = 0; i < 14; i++) begin
                    if (lv[i] == l && rm[i]) vec_q.push_back(16'h3 + 16'(8 * i));
                end
            end
            raise(rm, 3'h0, 6'h00);
            for (int k = 0; k < $countones(rm); k++) begin
                next_ack();
                ret();
            end
        end
        lv = '{14{2'h0}};
        lv[3] = 2'h1;
        lv[2] = 2'h1;
        lv[4] = 2'h2;
        lv[0] = 2'h3;
        lv[1] = 2'h3;
        set_lvls();
        vec_q.push_back(16'h001B);
        raise(14'h0008, 3'h0, 6'h00);
        next_ack();
        raise(14'h0004, 3'h0, 6'h00);
        idle(20);
        vec_q.push_back(16'h0023);
        raise(14'h0010, 3'h0, 6'h00);
        next_ack();
        vec_q.push_back(16'h0003);
        raise(14'h0001, 3'h0, 6'h00);
        next_ack();
        raise(14'h0002, 3'h0, 6'h00);
        idle(20);
        wr(`VIPU_OFS_NMI_CONTROL_REG, 32'h01);
        vec_q.push_back(16'h0073);
        raise(14'h0000, 3'h0, 6'h01);
        next_ack();
        ret();
        idle(10);
        vec_q.push_back(16'h000B);
        ret();
        next_ack();
        ret();
        ret();
        idle(10);
        vec_q.push_back(16'h0013);
        ret();
        next_ack();
        ret();
        wr(`VIPU_OFS_ENB, 32'hFD);
        raise(14'h0080, 3'h0, 6'h00);
        idle(20);
        vec_q.push_back(16'h003B);
        wr(`VIPU_OFS_ENB, 32'hFF);
        next_ack();
        ret();
        for (int k = 0; k < 3; k++) begin
            vec_q.push_back(16'h002B);
            raise(14'h0000, 3'(1 << k) | 3'($urandom_range(7, 0)), 6'h00);
            next_ack();
            ret();
        end
        for (int k = 0; k < 6; k++) begin
            wr(`VIPU_OFS_NMI_CONTROL_REG, 32'h00);
            raise(14'h0000, 3'h0, 6'(1 << k) | 6'($urandom_range(63, 0)));
            idle(20);
            vec_q.push_back(16'h0073);
            wr(`VIPU_OFS_NMI_CONTROL_REG, 32'(1 << k));
            next_ack();
            ret();
        end
        rd(`VIPU_OFS_IRQ_STAT, 32'h7);
        chk("irq", 32'h1, 32'(irq));
        wr(`VIPU_OFS_IRQ_EN, 32'h0);
        idle(2);
        chk("irq", 32'h0, 32'(irq));
        wr(`VIPU_OFS_IRQ_CLR, 32'h5);
        rd(`VIPU_OFS_IRQ_STAT, 32'h2);
        wr(`VIPU_OFS_IRQ_EN, 32'h2);
        idle(2);
        chk("irq", 32'h1, 32'(irq));
        wr(`VIPU_OFS_IRQ_CLR, 32'h7);
        rd(`VIPU_OFS_IRQ_STAT, 32'h0);
        idle(2);
        chk("irq", 32'h0, 32'(irq));
        chk("pending", 32'h0, 32'(vec_q.size() + rd_q.size()));
        chk("int_req", 32'h0, 32'(int_req));
        final_report();
    end
endmodule
`default_nettype wire
